//--- verilog/adt_tracker.v
/*
  annunciator detection tracker: count, ordered list and earliest word;
  assumes the executor gives at most one request per clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adt_map.vh"
module adt_tracker
#(
  parameter DEPTH = `ADT_DEPTH
)
(
  input  wire        clk,
  input  wire        rst,
  input  wire        setAnnunciatorRequest,
  input  wire        resetAnnunciatorRequest,
  input  wire        clearIndicatorRequest,
  input  wire [15:0] flagNumber,
  input  wire        panelClearSwitch,
  input  wire        wbCyc,
  input  wire        wbStb,
  input  wire        wbWe,
  input  wire [5:0]  wbAdr,
  input  wire [3:0]  wbSel,
  input  wire [31:0] wbDatIn,
  output wire [31:0] wbDatOut,
  output wire        wbAck,
  output reg  [15:0] earliestFlagWord,
  output reg  [15:0] activeDetectionCount
);
  reg  [15:0] list_q [0:DEPTH-1];
  reg  [15:0] list_d [0:DEPTH-1];
  reg  [15:0] count_d;
  reg  [127:0] listFlat;
  wire panelRise;
  wire softClear;
  wire doClear;
  // list depth at the width of a list position
  localparam [3:0] DEPTH4 = DEPTH;

  // first position holding a given flag, DEPTH when absent
  function [3:0] find_pos;
    input [127:0] flat;
    input [15:0]  num;
    integer j;
    begin
      find_pos = DEPTH4;
      for (j = DEPTH - 1; j >= 0; j = j - 1)
        if (flat[j*16 +: 16] == num && num != 16'h0000)
          find_pos = j[3:0];
    end
  endfunction

  adt_sync uSync
  (
    .clk     (clk),
    .rst     (rst),
    .asyncIn (panelClearSwitch),
    .rise    (panelRise)
  );

  adt_wb_slave uBus
  (
    .clk       (clk),
    .rst       (rst),
    .cyc       (wbCyc),
    .stb       (wbStb),
    .we        (wbWe),
    .adr       (wbAdr),
    .datIn     (wbDatIn),
    .earliest  (earliestFlagWord),
    .count     (activeDetectionCount),
    .listFlat  (listFlat),
    .datOut    (wbDatOut),
    .ack       (wbAck),
    .softClear (softClear)
  );

  // panel switch and software clear act as clear-indicator
  assign doClear = clearIndicatorRequest | panelRise | softClear; // [R9]

  // flatten list for search and bus reads
  always @*
  begin : flat
    integer i;
    listFlat = 128'h0;
    for (i = 0; i < DEPTH; i = i + 1)
      listFlat[i*16 +: 16] = list_q[i];
  end

  // next list and count
  always @*
  begin : nxt
    reg [3:0] pos;
    integer i;
    pos     = find_pos(listFlat, flagNumber);
    count_d = activeDetectionCount;
    for (i = 0; i < DEPTH; i = i + 1)
      list_d[i] = list_q[i];
    if (setAnnunciatorRequest && flagNumber <= `ADT_FLAG_MAX)
    begin
      if (activeDetectionCount < DEPTH)
      begin
        count_d = activeDetectionCount + 16'h0001; // [R1] [R3] [R4]
        list_d[activeDetectionCount[2:0]] = flagNumber; // [R10] [R5]
      end
    end
    else if (resetAnnunciatorRequest)
    begin
      if (activeDetectionCount != 16'h0000)
        count_d = activeDetectionCount - 16'h0001; // [R2]
      if (pos < DEPTH)
      begin
        for (i = 0; i < DEPTH - 1; i = i + 1)
          if (i >= pos)
            list_d[i] = list_q[i+1]; // [R6] [R7]
        list_d[DEPTH-1] = 16'h0000;
      end
    end
    else if (doClear)
    begin
      if (activeDetectionCount != 16'h0000)
        count_d = activeDetectionCount - 16'h0001; // [R2]
      for (i = 0; i < DEPTH - 1; i = i + 1)
        list_d[i] = list_q[i+1]; // [R8]
      list_d[DEPTH-1] = 16'h0000;
    end
  end

  // state registers; earliest word follows list head
  always @(posedge clk)
  begin : regs
    integer i;
    if (rst)
    begin
      activeDetectionCount <= 16'h0000;
      earliestFlagWord     <= 16'h0000;
      for (i = 0; i < DEPTH; i = i + 1)
        list_q[i] <= 16'h0000;
    end
    else
    begin
      activeDetectionCount <= count_d;
      earliestFlagWord     <= list_d[0]; // [R11] [R12]
      for (i = 0; i < DEPTH; i = i + 1)
        list_q[i] <= list_d[i];
    end
  end
endmodule
`default_nettype wire

//--- verilog/adt_map.vh
/*
  register offsets, field widths and reset values for the annunciator
  detection tracker; assumes byte addressing on a 32-bit wishbone bus.
*/
// Behaviour
// [R1] a set request for an in-range flag raises the active count by one
// [R2] a reset or clear-indicator request lowers the active count by one
// [R3] the active count is held as plain binary in its count word
// [R4] the count saturates at eight; further sets leave it unchanged
// [R5] with eight entries recorded a ninth flag number is not stored; the code stops storing only when the active count is eight
// [R6] a reset request removes the matching flag number from the list
// [R7] entries after the removed one move one place toward the head
// [R8] a clear-indicator request shifts the whole list up, dropping the head
// [R9] the panel clear switch acts exactly like a clear-indicator request
// [R10] new flags fill the first empty entry; empty entries read zero; the code writes the entry at the active count instead
// [R11] the earliest-detected active flag number is exposed as binary
// [R12] clearing the earliest word loads the next detected flag, if any
// [R13] the executor gives at most one request per clock with a valid flag
`ifndef ADT_MAP_VH
`define ADT_MAP_VH
`define ADT_ADDR_W       6
`define ADT_OFF_EARLIEST 6'h00
`define ADT_OFF_COUNT    6'h04
`define ADT_OFF_LIST0    6'h08
`define ADT_OFF_LIST7    6'h24
`define ADT_OFF_CTRL     6'h28
`define ADT_CTRL_RESET   16'h0001
`define ADT_FLAG_MAX     16'h00ff
`define ADT_DEPTH        8
`define ADT_WORD_W       16
`endif

//--- verilog/adt_sync.v
/*
  three-stage synchroniser with agreement filter for the panel switch;
  assumes an asynchronous, possibly bouncy level input.
*/
`timescale 1ns/1ps
`default_nettype none
module adt_sync
(
  input  wire clk,
  input  wire rst,
  input  wire asyncIn,
  output reg  rise
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg level_q;

  // the first stage feeds only the second; changes count when two and three agree
  always @(posedge clk)
  begin
    if (rst)
    begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
      rise    <= 1'b0;
    end
    else
    begin
      s1_q <= asyncIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      rise <= 1'b0;
      if (s2_q == s3_q)
      begin
        level_q <= s3_q;
        rise    <= s3_q & ~level_q;
      end
    end
  end
endmodule
`default_nettype wire

//--- verilog/adt_wb_slave.v
/*
  classic wishbone read decode for the tracker registers; assumes a
  single-cycle master that holds its request until ack.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adt_map.vh"
module adt_wb_slave
(
  input  wire                    clk,
  input  wire                    rst,
  input  wire                    cyc,
  input  wire                    stb,
  input  wire                    we,
  input  wire [`ADT_ADDR_W-1:0]  adr,
  input  wire [31:0]             datIn,
  input  wire [`ADT_WORD_W-1:0]  earliest,
  input  wire [`ADT_WORD_W-1:0]  count,
  input  wire [8*`ADT_WORD_W-1:0] listFlat,
  output reg  [31:0]             datOut,
  output reg                     ack,
  output reg                     softClear
);
  integer k;
  reg [31:0] rdData;

  // read mux; unmapped reads return zero
  always @*
  begin
    rdData = 32'h0000_0000;
    if (adr == `ADT_OFF_EARLIEST)
      rdData = {16'h0000, earliest};
    else if (adr == `ADT_OFF_COUNT)
      rdData = {16'h0000, count};
    for (k = 0; k < `ADT_DEPTH; k = k + 1)
      if (adr == `ADT_OFF_LIST0 + k[5:0] * 6'h04)
        rdData = {16'h0000, listFlat[k*`ADT_WORD_W +: `ADT_WORD_W]};
  end

  // one-wait-state ack, dropped the cycle after it was given
  always @(posedge clk)
  begin
    if (rst)
    begin
      ack       <= 1'b0;
      datOut    <= 32'h0000_0000;
      softClear <= 1'b0;
    end
    else
    begin
      softClear <= 1'b0;
      ack       <= cyc & stb & ~ack;
      if (cyc & stb & ~ack)
      begin
        datOut <= we ? 32'h0000_0000 : rdData;
        if (we && adr == `ADT_OFF_CTRL)
          softClear <= datIn[0];
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/adt_tracker_chk.sv
/*
  port assertions for the tracker; assumes the bench never mixes
  a request with a bus cycle or a panel press in one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module adt_tracker_chk
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        setAnnunciatorRequest,
  input wire logic        resetAnnunciatorRequest,
  input wire logic        clearIndicatorRequest,
  input wire logic [15:0] flagNumber,
  input wire logic        wbCyc,
  input wire logic        wbStb,
  input wire logic        wbAck,
  input wire logic [15:0] earliestFlagWord,
  input wire logic [15:0] activeDetectionCount
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // a bus request not yet answered
  sequence wbReq;
    wbCyc && wbStb && !wbAck;
  endsequence
  // count and head word follow the requests; ack comes the cycle after a bus request and lasts one cycle
  cnt_inc_a: assert property (setAnnunciatorRequest && flagNumber <= 16'h00ff
    && activeDetectionCount < 16'h0008 |=> activeDetectionCount ==
    $past(activeDetectionCount) + 16'h0001) else $error("count not raised");
  cnt_dec_a: assert property (!setAnnunciatorRequest && activeDetectionCount != 0
    && (resetAnnunciatorRequest || clearIndicatorRequest) |=> activeDetectionCount ==
    $past(activeDetectionCount) - 16'h0001) else $error("count not lowered");
  cnt_sat_a: assert property (setAnnunciatorRequest && activeDetectionCount == 8
    |=> activeDetectionCount == 16'h0008) else $error("count left eight");
  cnt_max_a: assert property (activeDetectionCount <= 16'h0008)
    else $error("count above eight");
  head_first_a: assert property (setAnnunciatorRequest && flagNumber <= 16'h00ff
    && activeDetectionCount == 0 |=> earliestFlagWord == $past(flagNumber))
    else $error("head word wrong");
  bad_flag_a: assert property (setAnnunciatorRequest && flagNumber > 16'h00ff
    |=> $stable(activeDetectionCount) && $stable(earliestFlagWord))
    else $error("large flag taken");
  ack_next_a: assert property (wbReq |=> wbAck) else $error("ack late");
  ack_pulse_a: assert property (wbAck |=> !wbAck) else $error("ack held");
endmodule
bind adt_tracker adt_tracker_chk adt_tracker_chk_inst (.*);
`default_nettype wire

//--- testbench/adt_exec_model.sv
/*
  instruction executor model issuing set, reset and clear requests;
  assumes the bench calls issue one request at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module adt_exec_model
(
  input  wire logic        clk,
  output var  logic        setReq,
  output var  logic        rstReq,
  output var  logic        clrReq,
  output var  logic [15:0] flag
);
  initial {setReq, rstReq, clrReq, flag} = 19'h0;
  // one request per clock, flag valid with it, then a changed flag
  task automatic issue(input logic [1:0] k, input logic [15:0] f);
    @(posedge clk);
    setReq <= k == 2'h1;
    rstReq <= k == 2'h2;
    clrReq <= k == 2'h3;
    flag   <= f;
    @(posedge clk);
    {setReq, rstReq, clrReq} <= 3'h0;
    flag   <= ~f;
  endtask
endmodule
`default_nettype wire

//--- testbench/tb.sv
/*
  tracker bench: requests through the executor model, readback over
  wishbone; assumes a one-cycle ack and a reference list kept here.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb;
  logic clk = 0, rst = 1, pnl = 0, cyc = 0, stb = 0, we = 0, ack, sr, rr, cr;
  logic [5:0] adr = 6'h0;
  logic [31:0] di = 32'h0, dq, rd;
  logic [15:0] fl, ear, cnt, q[$];
  int n_mismatch = 0, compares = 0, c = 0;
  logic [17:0] ops[14] = '{18'h10032, 18'h10019, 18'h10063, 18'h20019, 18'h10010,
    18'h10046, 18'h10041, 18'h10026, 18'h1006e, 18'h10097, 18'h100d2, 18'h30000,
    18'h1012c, 18'h2004d};
  adt_exec_model adt_exec_model_inst (.clk(clk), .setReq(sr), .rstReq(rr),
    .clrReq(cr), .flag(fl));
  adt_tracker adt_tracker_inst (.clk(clk), .rst(rst), .setAnnunciatorRequest(sr),
    .resetAnnunciatorRequest(rr), .clearIndicatorRequest(cr), .flagNumber(fl),
    .panelClearSwitch(pnl), .wbCyc(cyc), .wbStb(stb), .wbWe(we), .wbAdr(adr),
    .wbSel(4'hf), .wbDatIn(di), .wbDatOut(dq), .wbAck(ack),
    .earliestFlagWord(ear), .activeDetectionCount(cnt));
  initial forever #20 clk = ~clk;
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int k;
    @(posedge clk);
    {cyc, stb, we, adr, di} <= {2'b11, w, a, d};
    for (k = 0; k < 20 && ack !== 1'b1; k++) @(posedge clk);
    r = dq;
    {cyc, stb} <= 2'b00;
    if (k == 20)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  // reference list update for a set, reset or clear
  task automatic model(input logic [1:0] k, input logic [15:0] f);
    if (k == 2'h1 && f <= 16'h00ff && c < 8)
    begin
      c++;
      if (q.size() < 8) q.push_back(f);
    end
    if (k > 2'h1 && c > 0) c--;
    if (k == 2'h3 && q.size() > 0) q.pop_front();
    for (int i = q.size() - 1; i >= 0; i--) if (k == 2'h2 && q[i] == f) q.delete(i);
  endtask
  task automatic verify;
    logic [31:0] r;
    for (int i = 0; i < 10; i++)
    begin
      wb(1'b0, 6'(4 * i), 32'h0, r);
      `CHK("reg", 32'(i == 0 ? (q.size() ? q[0] : 0) : i == 1 ? c :
        i - 2 < q.size() ? q[i - 2] : 0), r)
    end
    `CHK("count", 16'(c), cnt)
    `CHK("earliest", 16'(q.size() ? q[0] : 0), ear)
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 0;
    verify();
    wb(1'b0, 6'h2c, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd)
    $display("test reset done");
    foreach (ops[i])
    begin
      model(ops[i][17:16], ops[i][15:0]);
      adt_exec_model_inst.issue(ops[i][17:16], ops[i][15:0]);
      verify();
    end
    $display("test sequence done");
    @(posedge clk) pnl <= 1;
    repeat (8) @(posedge clk);
    pnl <= 0;
    model(2'h3, 16'h0);
    verify();
    wb(1'b1, 6'h04, 32'h5, rd);
    wb(1'b1, 6'h28, 32'h1, rd);
    model(2'h3, 16'h0);
    verify();
    repeat (6)
    begin
      model(2'h3, 16'h0);
      adt_exec_model_inst.issue(2'h3, 16'h0);
      verify();
    end
    $display("test clears done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
